// ==== src/obd_map.svh ====
// Purpose: Bit positions, reset values and timing counts for the option byte decoder
// Assumes: Byte 0 and byte 1 are eight bits each
// Notes:   Definitions only
`ifndef OBD_MAP_SVH
`define OBD_MAP_SVH

// Byte 0 field positions
`define OBD_B0_WDG_HALT_BIT    7
`define OBD_B0_WDG_TYPE_BIT    6
`define OBD_B0_VD_BIT          4
`define OBD_B0_PLL_OFF_BIT     3
`define OBD_B0_PKG_HI          2
`define OBD_B0_PKG_LO          1
`define OBD_B0_RDP_BIT         0
// Byte 1 field positions
`define OBD_B1_REMAP_HI        7
`define OBD_B1_REMAP_LO        6
`define OBD_B1_CLOCK_SOURCE_TYPE_HI      5
`define OBD_B1_CLOCK_SOURCE_TYPE_LO      4
`define OBD_B1_RANGE_HI        3
`define OBD_B1_RANGE_LO        2
`define OBD_B1_RSTDLY_BIT      0
// Shipped contents
`define OBD_B0_DEFAULT         8'hFF
`define OBD_B1_DEFAULT         8'hEF
// Reset delay lengths in CPU cycles
`define OBD_DELAY_LONG         13'h1000
`define OBD_DELAY_SHORT        13'h0100

`endif

// ==== src/obd_pkg.sv ====
// Purpose: Types shared by the option byte decoder files
// Assumes: Nothing beyond the map header
// Notes:   Encodings follow the stored field values
package obd_pkg;

  typedef enum logic [1:0] {
    OBD_PKG_32 = 2'b00,
    OBD_PKG_44 = 2'b01,
    OBD_PKG_64 = 2'b10
  } obd_package_t;

  typedef enum logic [1:0] {
    OBD_CLK_RESONATOR = 2'b00,
    OBD_CLK_RESERVED  = 2'b01,
    OBD_CLK_INTERNAL  = 2'b10,
    OBD_CLK_EXTERNAL  = 2'b11
  } obd_clk_src_t;

  typedef enum logic [1:0] {
    OBD_RANGE_LOW_POWER    = 2'b00,
    OBD_RANGE_MEDIUM_POWER = 2'b01,
    OBD_RANGE_MEDIUM_SPEED = 2'b10,
    OBD_RANGE_HIGH_SPEED   = 2'b11
  } obd_osc_range_t;

  // Decoded settings handed to the core
  typedef struct packed {
    logic           voltage_detector_on;
    logic           clock_doubler_on;
    obd_package_t   package_select;
    logic           readout_protect;
    logic           watchdog_reset_on_halt;
    logic           watchdog_hw_always_on;
    logic           remap_compare_capture;
    logic           remap_capture_b;
    obd_clk_src_t   clock_source_type;
    obd_osc_range_t oscillator_range;
    logic           reset_delay_long;
  } obd_settings_t;

  // Pin routing decided by the remap bits
  typedef struct packed {
    logic compare_on_port_b;  // Compare outputs on PB6/PB7 instead of PD3/PD5
    logic capture_a_on_pc0;   // Capture A from PC0 instead of PD4
    logic serial_two_enable;  // Serial two on PD3/PD5/PD4
    logic capture_b_on_pc1;   // Capture B from PC1 instead of PD1
  } obd_routing_t;

endpackage : obd_pkg

// ==== src/obd_option_store.sv ====
// Purpose: Non-volatile holding place for the two option bytes
// Assumes: Written only in programming mode by the external tool
// Notes:   Read data comes out of a register
`timescale 1ns/10ps
`default_nettype none
`include "obd_map.svh"

module obd_option_store (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Access port
  input  wire logic       wr_en,
  input  wire logic       sel,
  input  wire logic [7:0] wr_data,
  input  wire logic       erase,
  output logic      [7:0] rd_data_0,
  output logic      [7:0] rd_data_1
);

  // A fresh part powers up holding the shipped pattern, never an unknown
  logic [7:0] byte_reg [2] = '{`OBD_B0_DEFAULT, `OBD_B1_DEFAULT};
  logic [7:0] byte_next [2];
  logic [7:0] rd0_reg      = `OBD_B0_DEFAULT;
  logic [7:0] rd1_reg      = `OBD_B1_DEFAULT;

  // Erase returns both bytes to their shipped contents
  always_comb begin
    byte_next[0] = byte_reg[0];
    byte_next[1] = byte_reg[1];
    if (erase) begin
      byte_next[0] = `OBD_B0_DEFAULT;
      byte_next[1] = `OBD_B1_DEFAULT;
    end else if (wr_en) begin
      byte_next[sel] = wr_data;
    end
  end

  // Contents survive rst, as a non-volatile cell would
  always_ff @(posedge clk) begin
    byte_reg[0] <= byte_next[0];
    byte_reg[1] <= byte_next[1];
    rd0_reg     <= byte_next[0];
    rd1_reg     <= byte_next[1];
  end

  assign rd_data_0 = rst ? rd0_reg : rd0_reg;
  assign rd_data_1 = rd1_reg;

endmodule : obd_option_store
`default_nettype wire

// ==== src/obd_delay_counter.sv ====
// Purpose: Counts the CPU cycles of the reset and halt-exit delay
// Assumes: Start pulse comes from the same clock
// Notes:   Busy is high for exactly the loaded number of cycles
`timescale 1ns/10ps
`default_nettype none

module obd_delay_counter #(
  parameter int WIDTH = 13
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Control
  input  wire logic             start,
  input  wire logic [WIDTH-1:0] length,
  output logic                  busy
);

  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;

  // Load on start, then count down to zero
  always_comb begin
    count_next = count_reg;
    if (start) begin
      count_next = length;
    end else if (count_reg != '0) begin
      count_next = count_reg - WIDTH'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  assign busy = (count_reg != '0);

endmodule : obd_delay_counter
`default_nettype wire

// ==== src/obd_option_decoder.sv ====
// Purpose: Decodes the two static option bytes into device settings
// Assumes: Bytes change only in programming mode; core leaves reset after capture
// Notes:   Settings are frozen from reset release until the next reset
`timescale 1ns/10ps
`default_nettype none
`include "obd_map.svh"

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - Voltage detector bit 0 turns detector on, 1 keeps it off.
// - Doubler disable bit 0 enables times-two multiplier, 1 bypasses it.
// - Package field: 1x gives 64 pins, 01 gives 44, 00 gives 32.
// - Pads unbonded in the chosen package become inputs with pull-up.
// - Protection bit 0 blocks memory read-out and flash writes.
// - Erasing bytes under protection first erases all user memory.
// - Remap bit 1 moves compare, capture A and serial two pins.
// - Remap bit 0 picks capture B from PD1 or PC1.
// - Clock type: 00 resonator, 01 reserved, 10 internal, 11 external.
// - Range field picks 1-2, 2-4, 4-8 or 8-16 MHz resonator.
// - Reset delay bit 0 gives 4096 cycles, 1 gives 256.
// - Shipped: byte 0 all ones, byte 1 all ones but low type bit.
// - Watchdog-on-halt bit 1 resets on halt entry while watchdog runs.
// - Watchdog type bit 0 keeps watchdog always on by hardware.
// - Option bytes are unmapped, reached only in programming mode.
module obd_option_decoder #(
  parameter int PAD_COUNT   = 48,
  parameter int DELAY_WIDTH = 13
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  // Programming port, live only in programming mode
  input  wire logic                  prog_mode,
  input  wire logic                  prog_wr_en,
  input  wire logic                  prog_sel,
  input  wire logic [7:0]            prog_wr_data,
  input  wire logic                  prog_erase,
  input  wire logic                  user_mem_erase_done,
  output logic                       user_mem_erase_req,
  output logic      [7:0]            prog_rd_data,
  // Pad bonding map per package
  input  wire logic [PAD_COUNT-1:0]  pad_bonded_44,
  input  wire logic [PAD_COUNT-1:0]  pad_bonded_32,
  output logic      [PAD_COUNT-1:0]  pad_force_input_pullup,
  // Core side events
  input  wire logic                  halt_entry,
  input  wire logic                  watchdog_running,
  input  wire logic                  halt_exit,
  input  wire logic                  watchdog_sw_enable,
  // Decoded settings
  output obd_pkg::obd_settings_t     settings,
  output obd_pkg::obd_routing_t      routing,
  output logic                       watchdog_enabled,
  output logic                       watchdog_halt_reset,
  output logic                       memory_readout_block,
  output logic                       flash_write_block,
  output logic                       reset_delay_busy
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode functions, used only to capture the shown settings from the stored bytes during reset

  function automatic obd_pkg::obd_package_t decode_package(input logic [1:0] f);
    obd_pkg::obd_package_t p;
    p = obd_pkg::OBD_PKG_32;
    if (f[1]) begin
      p = obd_pkg::OBD_PKG_64;
    end else if (f[0]) begin
      p = obd_pkg::OBD_PKG_44;
    end
    return p;
  endfunction : decode_package

  function automatic obd_pkg::obd_settings_t decode_bytes(input logic [7:0] b0,
                                                          input logic [7:0] b1);
    obd_pkg::obd_settings_t s;
    s.voltage_detector_on    = ~b0[`OBD_B0_VD_BIT];
    s.clock_doubler_on       = ~b0[`OBD_B0_PLL_OFF_BIT];
    s.package_select         = decode_package(b0[`OBD_B0_PKG_HI:`OBD_B0_PKG_LO]);
    s.readout_protect        = ~b0[`OBD_B0_RDP_BIT];
    s.watchdog_reset_on_halt = b0[`OBD_B0_WDG_HALT_BIT];
    s.watchdog_hw_always_on  = ~b0[`OBD_B0_WDG_TYPE_BIT];
    s.remap_compare_capture  = b1[`OBD_B1_REMAP_HI];
    s.remap_capture_b        = b1[`OBD_B1_REMAP_LO];
    s.clock_source_type      = obd_pkg::obd_clk_src_t'(b1[`OBD_B1_CLOCK_SOURCE_TYPE_HI:`OBD_B1_CLOCK_SOURCE_TYPE_LO]);
    s.oscillator_range       = obd_pkg::obd_osc_range_t'(b1[`OBD_B1_RANGE_HI:`OBD_B1_RANGE_LO]);
    s.reset_delay_long       = ~b1[`OBD_B1_RSTDLY_BIT];
    return s;
  endfunction : decode_bytes

  ////////////////////////////////////////////////////////////////////////////
  // Option storage; writes only reach it in programming mode

  typedef enum logic [1:0] {
    OBD_ST_IDLE    = 2'b00,
    OBD_ST_WIPE    = 2'b01,
    OBD_ST_CLEAR   = 2'b10
  } obd_erase_state_t;

  obd_erase_state_t erase_state_reg;
  obd_erase_state_t erase_state_next;
  logic [7:0]       store_b0;
  logic [7:0]       store_b1;
  logic             store_wr;
  logic             store_erase;
  logic             protected_now;

  assign protected_now = ~store_b0[`OBD_B0_RDP_BIT];
  // Protected parts refuse byte writes until an erase clears protection
  assign store_wr      = prog_mode && prog_wr_en && !protected_now
                         && (erase_state_reg == OBD_ST_IDLE);
  assign store_erase   = (erase_state_reg == OBD_ST_CLEAR);

  obd_option_store u_store (
    .clk       (clk),
    .rst       (rst),
    .wr_en     (store_wr),
    .sel       (prog_sel),
    .wr_data   (prog_wr_data),
    .erase     (store_erase),
    .rd_data_0 (store_b0),
    .rd_data_1 (store_b1)
  );

  // Erase sequence: user memory first when protected, then option bytes
  always_comb begin
    erase_state_next = erase_state_reg;
    unique case (erase_state_reg)
      OBD_ST_IDLE: begin
        if (prog_mode && prog_erase) begin
          erase_state_next = protected_now ? OBD_ST_WIPE : OBD_ST_CLEAR;
        end
      end
      OBD_ST_WIPE: begin
        if (user_mem_erase_done) begin
          erase_state_next = OBD_ST_CLEAR;
        end
      end
      OBD_ST_CLEAR: begin
        erase_state_next = OBD_ST_IDLE;
      end
      default: begin
        erase_state_next = OBD_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      erase_state_reg <= OBD_ST_IDLE;
    end else begin
      erase_state_reg <= erase_state_next;
    end
  end

  assign user_mem_erase_req = (erase_state_reg == OBD_ST_WIPE);

  ////////////////////////////////////////////////////////////////////////////
  // Programming read-back, registered; zero outside programming mode

  logic [7:0] rd_reg;
  logic [7:0] rd_next;

  always_comb begin
    rd_next = 8'h00;
    if (prog_mode) begin
      rd_next = prog_sel ? store_b1 : store_b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rd_reg <= 8'h00;
    end else begin
      rd_reg <= rd_next;
    end
  end

  assign prog_rd_data = rd_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Capture during reset, freeze afterwards

  obd_pkg::obd_settings_t set_reg;
  obd_pkg::obd_settings_t set_next;
  logic                   rst_seen_reg;

  // Each reset cycle loads the decode of the stored bytes; the last one is kept
  always_comb begin
    set_next = set_reg;
    if (rst) begin
      set_next = decode_bytes(store_b0, store_b1);
    end
  end

  always_ff @(posedge clk) begin
    set_reg <= set_next;
  end

  // Delay starts on reset release and on each halt exit
  always_ff @(posedge clk) begin
    if (rst) begin
      rst_seen_reg <= 1'b1;
    end else begin
      rst_seen_reg <= 1'b0;
    end
  end

  assign settings = set_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Derived controls

  logic [DELAY_WIDTH-1:0] delay_len;

  assign delay_len = set_reg.reset_delay_long ? DELAY_WIDTH'(`OBD_DELAY_LONG)
                                              : DELAY_WIDTH'(`OBD_DELAY_SHORT);

  obd_delay_counter #(
    .WIDTH (DELAY_WIDTH)
  ) u_delay (
    .clk    (clk),
    .rst    (rst),
    .start  (rst_seen_reg | halt_exit),
    .length (delay_len),
    .busy   (reset_delay_busy)
  );

  // Pin routing from the remap bits
  assign routing.compare_on_port_b = set_reg.remap_compare_capture;
  assign routing.capture_a_on_pc0  = set_reg.remap_compare_capture;
  assign routing.serial_two_enable = set_reg.remap_compare_capture;
  assign routing.capture_b_on_pc1  = set_reg.remap_capture_b;

  // Watchdog: hardware type cannot be turned off
  assign watchdog_enabled    = set_reg.watchdog_hw_always_on | watchdog_sw_enable;
  assign watchdog_halt_reset = halt_entry & watchdog_running
                               & set_reg.watchdog_reset_on_halt;

  // Protection also covers programming-mode access
  assign memory_readout_block = set_reg.readout_protect;
  assign flash_write_block    = set_reg.readout_protect;

  // Unbonded pads; the 64-pin package bonds every pad
  genvar gi;
  generate
    for (gi = 0; gi < PAD_COUNT; gi++) begin : g_pad
      always_comb begin
        unique case (set_reg.package_select)
          obd_pkg::OBD_PKG_44: pad_force_input_pullup[gi] = ~pad_bonded_44[gi];
          obd_pkg::OBD_PKG_32: pad_force_input_pullup[gi] = ~pad_bonded_32[gi];
          default:             pad_force_input_pullup[gi] = 1'b0;
        endcase
      end
    end
  endgenerate

endmodule : obd_option_decoder
`default_nettype wire

// ==== tb/obd_option_monitor.sv ====
// Purpose: Concurrent checks on the option decoder ports
// Assumes: Single clock domain, sync active-high reset
// Notes:   Attached to every decoder instance by bind
`timescale 1ns/10ps
`default_nettype none

module obd_option_monitor #(
  parameter int PAD_COUNT = 48
) (
  // Clock and reset
  input wire logic                   clk,
  input wire logic                   rst,
  // Programming side
  input wire logic                   prog_mode,
  input wire logic [7:0]             prog_rd_data,
  input wire logic                   user_mem_erase_req,
  input wire logic                   user_mem_erase_done,
  // Pads and events
  input wire logic [PAD_COUNT-1:0]   pad_bonded_44,
  input wire logic [PAD_COUNT-1:0]   pad_force_input_pullup,
  input wire logic                   halt_entry,
  input wire logic                   watchdog_running,
  // Decoded outputs
  input wire obd_pkg::obd_settings_t settings,
  input wire obd_pkg::obd_routing_t  routing,
  input wire logic                   watchdog_enabled,
  input wire logic                   watchdog_halt_reset,
  input wire logic                   memory_readout_block,
  input wire logic                   flash_write_block,
  input wire logic                   reset_delay_busy
);
  logic [15:0] busy_cnt_reg;
  logic [15:0] busy_cnt_next;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////
  // Busy length counter, cleared whenever busy is low so each run counts alone
  always_comb begin
    busy_cnt_next = reset_delay_busy ? busy_cnt_reg + 16'h0001 : 16'h0000;
  end
  always_ff @(posedge clk) begin
    busy_cnt_reg <= rst ? 16'h0000 : busy_cnt_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Properties
  property p_rd_idle;
    !prog_mode |=> prog_rd_data == 8'h00;
  endproperty
  property p_block_pair;
    memory_readout_block == flash_write_block;
  endproperty
  property p_route_a;
    routing.compare_on_port_b == settings.remap_compare_capture && routing.capture_a_on_pc0 ==
    settings.remap_compare_capture && routing.serial_two_enable == settings.remap_compare_capture;
  endproperty
  property p_route_b;
    routing.capture_b_on_pc1 == settings.remap_capture_b;
  endproperty
  property p_wdg_halt;
    watchdog_halt_reset == (halt_entry && watchdog_running && settings.watchdog_reset_on_halt);
  endproperty
  property p_wdg_hw;
    settings.watchdog_hw_always_on |-> watchdog_enabled;
  endproperty
  property p_frozen;
    !$past(rst) |-> $stable(settings);
  endproperty
  property p_pads64;
    settings.package_select == obd_pkg::OBD_PKG_64 |-> pad_force_input_pullup == '0;
  endproperty
  property p_pads44;
    settings.package_select == obd_pkg::OBD_PKG_44 |-> pad_force_input_pullup == ~pad_bonded_44;
  endproperty
  // Tolerates busy starting up to three edges after release
  property p_busy_start;
    $fell(rst) |-> ##3 reset_delay_busy [*8];
  endproperty
  property p_busy_len;
    $fell(reset_delay_busy) |-> busy_cnt_reg == (settings.reset_delay_long ? 16'h1000 : 16'h0100);
  endproperty
  property p_erase_hold;
    user_mem_erase_req && !user_mem_erase_done |=> user_mem_erase_req;
  endproperty

  a_rd_idle:    assert property (p_rd_idle)    else $error("option read data not zero outside programming");
  a_block_pair: assert property (p_block_pair) else $error("read-out and write blocks disagree");
  a_route_a:    assert property (p_route_a)    else $error("compare and serial routing wrong");
  a_route_b:    assert property (p_route_b)    else $error("capture b routing wrong");
  a_wdg_halt:   assert property (p_wdg_halt)   else $error("halt watchdog reset wrong");
  a_wdg_hw:     assert property (p_wdg_hw)     else $error("hardware watchdog not enabled");
  a_frozen:     assert property (p_frozen)     else $error("settings changed outside reset");
  a_pads64:     assert property (p_pads64)     else $error("pads forced in large package");
  a_pads44:     assert property (p_pads44)     else $error("pad forcing wrong in mid package");
  a_busy_start: assert property (p_busy_start) else $error("delay not running after reset");
  a_busy_len:   assert property (p_busy_len)   else $error("delay length wrong");
  a_erase_hold: assert property (p_erase_hold) else $error("memory wipe request dropped early");

  c_busy_end:   cover property ($fell(reset_delay_busy));
  c_erase:      cover property ($rose(user_mem_erase_req));
  c_halt_reset: cover property (watchdog_halt_reset);
endmodule : obd_option_monitor

bind obd_option_decoder obd_option_monitor #(.PAD_COUNT(PAD_COUNT)) obd_option_monitor_i (.clk, .rst, .prog_mode,
  .prog_rd_data, .user_mem_erase_req, .user_mem_erase_done, .pad_bonded_44, .pad_force_input_pullup, .halt_entry,
  .watchdog_running, .settings, .routing, .watchdog_enabled, .watchdog_halt_reset, .memory_readout_block,
  .flash_write_block, .reset_delay_busy);
`default_nettype wire

// ==== tb/obd_prog_tool.sv ====
// Purpose: Programming tool and user memory eraser seen from the decoder
// Assumes: Signals change on the falling edge only
// Notes:   Write data is inverted once released so stale values never match
`timescale 1ns/10ps
`default_nettype none

module obd_prog_tool (
  // Clock and mode
  input  wire logic       clk,
  input  wire logic       slow,
  // Decoder answers
  input  wire logic       user_mem_erase_req,
  input  wire logic [7:0] prog_rd_data,
  // Programming port
  output logic            prog_mode,
  output logic            prog_wr_en,
  output logic            prog_sel,
  output logic [7:0]      prog_wr_data,
  output logic            prog_erase,
  output logic            user_mem_erase_done
);
  int wait_cnt;

  initial begin
    prog_mode = 1'b1;
    prog_wr_en = 1'b0;
    prog_sel = 1'b0;
    prog_wr_data = 8'h00;
    prog_erase = 1'b0;
    user_mem_erase_done = 1'b0;
    wait_cnt = 0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Option access only while in programming mode
  task automatic set_mode(input logic m);
    @(negedge clk);
    prog_mode = m;
  endtask : set_mode
  task automatic write_byte(input logic s, input logic [7:0] d);
    @(negedge clk);
    prog_sel = s;
    prog_wr_data = d;
    prog_wr_en = 1'b1;
    @(negedge clk);
    prog_wr_en = 1'b0;
    prog_wr_data = ~d;
  endtask : write_byte
  task automatic read_byte(input logic s, output logic [7:0] v);
    @(negedge clk);
    prog_sel = s;
    repeat (2) @(negedge clk);
    v = prog_rd_data;
  endtask : read_byte
  task automatic erase_bytes;
    @(negedge clk);
    prog_erase = 1'b1;
    @(negedge clk);
    prog_erase = 1'b0;
  endtask : erase_bytes

  ////////////////////////////////////////////////////////////////////////////
  // Memory wiper, answers promptly or slowly on request
  always @(negedge clk) begin
    user_mem_erase_done <= 1'b0;
    if (user_mem_erase_req && !user_mem_erase_done) begin
      wait_cnt <= wait_cnt + 1;
      if (wait_cnt >= (slow ? 20 : 1)) begin
        user_mem_erase_done <= 1'b1;
        wait_cnt <= 0;
      end
    end
  end
endmodule : obd_prog_tool
`default_nettype wire

// ==== tb/test_option_byte_decoder.sv ====
// Purpose: Self-checking bench for the option byte decoder
// Assumes: Fixed seed, inputs driven on the falling edge
// Notes:   Each byte pair is loaded by a full reset before checking
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin error_cnt++; \
  $display("BAD t=%0t got=%0h exp=%0h", $time, a, e); end end

module test_option_byte_decoder;
  logic clk, rst, halt_entry, watchdog_running, halt_exit, watchdog_sw_enable, slow;
  logic prog_mode, prog_wr_en, prog_sel, prog_erase, user_mem_erase_done, user_mem_erase_req;
  logic [7:0] prog_wr_data, prog_rd_data, b0, b1, v;
  logic [47:0] pad_bonded_44, pad_bonded_32, pad_force_input_pullup;
  obd_pkg::obd_settings_t settings;
  obd_pkg::obd_routing_t routing;
  logic watchdog_enabled, watchdog_halt_reset, memory_readout_block, flash_write_block, reset_delay_busy;
  int error_cnt, total_checks, k;
  logic [31:0] r;

  obd_option_decoder #(.PAD_COUNT(48), .DELAY_WIDTH(13)) obd_option_decoder_i (.clk(clk), .rst(rst),
    .prog_mode(prog_mode), .prog_wr_en(prog_wr_en), .prog_sel(prog_sel), .prog_wr_data(prog_wr_data),
    .prog_erase(prog_erase), .user_mem_erase_done(user_mem_erase_done), .user_mem_erase_req(user_mem_erase_req),
    .prog_rd_data(prog_rd_data), .pad_bonded_44(pad_bonded_44), .pad_bonded_32(pad_bonded_32),
    .pad_force_input_pullup(pad_force_input_pullup), .halt_entry(halt_entry), .watchdog_running(watchdog_running),
    .halt_exit(halt_exit), .watchdog_sw_enable(watchdog_sw_enable), .settings(settings), .routing(routing),
    .watchdog_enabled(watchdog_enabled), .watchdog_halt_reset(watchdog_halt_reset),
    .memory_readout_block(memory_readout_block), .flash_write_block(flash_write_block),
    .reset_delay_busy(reset_delay_busy));
  obd_prog_tool obd_prog_tool_i (.clk(clk), .slow(slow), .user_mem_erase_req(user_mem_erase_req),
    .prog_rd_data(prog_rd_data), .prog_mode(prog_mode), .prog_wr_en(prog_wr_en), .prog_sel(prog_sel),
    .prog_wr_data(prog_wr_data), .prog_erase(prog_erase), .user_mem_erase_done(user_mem_erase_done));

  always #2.5 clk = ~clk;
  // Core events other than halt exit toggle at random all run long
  always @(negedge clk) begin
    halt_entry <= 1'($urandom);
    watchdog_running <= 1'($urandom);
    watchdog_sw_enable <= 1'($urandom);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Expected decode; protection field is judged through the block outputs
  function automatic obd_pkg::obd_settings_t exp_set(input logic [7:0] x0, input logic [7:0] x1);
    obd_pkg::obd_settings_t e;
    e.voltage_detector_on = !x0[4];
    e.clock_doubler_on = !x0[3];
    e.package_select = x0[2] ? obd_pkg::OBD_PKG_64 : obd_pkg::obd_package_t'(x0[2:1]);
    e.readout_protect = 1'b0;
    e.watchdog_reset_on_halt = x0[7];
    e.watchdog_hw_always_on = !x0[6];
    e.remap_compare_capture = x1[7];
    e.remap_capture_b = x1[6];
    e.clock_source_type = obd_pkg::obd_clk_src_t'(x1[5:4]);
    e.oscillator_range = obd_pkg::obd_osc_range_t'(x1[3:2]);
    e.reset_delay_long = !x1[0];
    return e;
  endfunction : exp_set

  task automatic wrap_up;
    if (error_cnt == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrap_up

  task automatic do_reset;
    @(negedge clk);
    rst = 1'b1;
    repeat (6) @(negedge clk);
    rst = 1'b0;
  endtask : do_reset

  // Counts busy cycles from the calling edge on; a delay that never ends fails
  task automatic meas_busy(input int exp_n);
    int n;
    n = 0;
    for (k = 0; k < 5000 && !(n > 0 && !reset_delay_busy); k++) begin
      if (reset_delay_busy === 1'b1) n++;
      @(negedge clk);
    end
    if (k == 5000) begin
      error_cnt++;
      wrap_up();
    end
    `CHK(n, exp_n)
  endtask : meas_busy

  task automatic chk_all(input logic [7:0] x0, input logic [7:0] x1);
    obd_pkg::obd_settings_t s;
    obd_pkg::obd_routing_t ro;
    s = settings;
    s.readout_protect = 1'b0;
    ro = {x1[7], x1[7], x1[7], x1[6]};
    `CHK(s, exp_set(x0, x1))
    `CHK(routing, ro)
    `CHK(pad_force_input_pullup, x0[2] ? 48'h0 : (x0[1] ? ~pad_bonded_44 : ~pad_bonded_32))
    `CHK(memory_readout_block, !x0[0])
    `CHK(flash_write_block, !x0[0])
    meas_busy(x1[0] ? 256 : 4096);
  endtask : chk_all

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    halt_exit = 1'b0;
    slow = 1'b0;
    halt_entry = 1'b0;
    watchdog_running = 1'b0;
    watchdog_sw_enable = 1'b0;
    error_cnt = 0;
    total_checks = 0;
    r = $urandom(76062);
    pad_bonded_44 = 48'({$urandom(), $urandom()});
    pad_bonded_32 = 48'({$urandom(), $urandom()});
    do_reset();
    chk_all(8'hFF, 8'hEF);
    // A fresh part holds shipped contents, and erase must restore them
    obd_prog_tool_i.erase_bytes();
    obd_prog_tool_i.read_byte(1'b0, v);
    `CHK(v, 8'hFF)
    obd_prog_tool_i.read_byte(1'b1, v);
    `CHK(v, 8'hEF)
    do_reset();
    chk_all(8'hFF, 8'hEF);
    // Every package, clock type and range code; watchdog, detector and remap bits random
    for (int i = 0; i < 16; i++) begin
      r = $urandom();
      b0 = {r[7:6], 1'b1, r[4], (i[3:2] == 2'b01) ? r[3] : 1'b1, i[1:0], 1'b1};
      b1 = {r[15:14], i[1:0], i[3:2], 1'b1, (i[1:0] == 2'b00) ? 1'b0 : r[8]};
      obd_prog_tool_i.write_byte(1'b1, b1);
      obd_prog_tool_i.write_byte(1'b0, b0);
      obd_prog_tool_i.read_byte(1'b1, v);
      `CHK(v, b1)
      obd_prog_tool_i.read_byte(1'b0, v);
      `CHK(v, b0)
      do_reset();
      chk_all(b0, b1);
      if (i == 15) begin
        @(negedge clk);
        halt_exit = 1'b1;
        @(negedge clk);
        halt_exit = 1'b0;
        meas_busy(b1[0] ? 256 : 4096);
      end
    end
    // Protected part refuses writes, then a slow wipe precedes the erase
    obd_prog_tool_i.write_byte(1'b0, 8'hFE);
    do_reset();
    `CHK(memory_readout_block, 1'b1)
    obd_prog_tool_i.write_byte(1'b1, ~b1);
    obd_prog_tool_i.read_byte(1'b1, v);
    `CHK(v, b1)
    slow = 1'b1;
    obd_prog_tool_i.erase_bytes();
    for (k = 0; k < 100 && user_mem_erase_req !== 1'b0; k++) @(negedge clk);
    if (k == 100) begin
      error_cnt++;
      wrap_up();
    end
    obd_prog_tool_i.read_byte(1'b1, v);
    `CHK(v, 8'hEF)
    obd_prog_tool_i.read_byte(1'b0, v);
    `CHK(v, 8'hFF)
    obd_prog_tool_i.set_mode(1'b0);
    repeat (2) @(negedge clk);
    `CHK(prog_rd_data, 8'h00)
    wrap_up();
  end
endmodule : test_option_byte_decoder
`default_nettype wire
